// ---- include/fpr_pkg.sv ----
/*
  Constants, register map and state type of the single-precision result unit.
  Assumes a 32-bit classic Wishbone slave with byte addresses on an 8-bit address.
*/
package fpr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int         ADR_W        = 8;
  localparam logic [7:0] ADR_OPA      = 8'h00;
  localparam logic [7:0] ADR_OPB      = 8'h04;
  localparam logic [7:0] ADR_CTRL     = 8'h08;
  localparam logic [7:0] ADR_RESULT   = 8'h0C;
  localparam logic [7:0] ADR_FLAGS    = 8'h10;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h18;

  // ----------------------------------------
  // Operation codes, CTRL bits 2:0
  // ----------------------------------------
  localparam logic [2:0] OP_ADD   = 3'h0;
  localparam logic [2:0] OP_SUB   = 3'h1;
  localparam logic [2:0] OP_MUL   = 3'h2;
  localparam logic [2:0] OP_DIV   = 3'h3;
  localparam logic [2:0] OP_CMP   = 3'h4;
  localparam logic [2:0] OP_FIX16 = 3'h5;
  localparam logic [2:0] OP_FIX32 = 3'h6;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLG_BUSY = 0;
  localparam int FLG_ZERO = 1;
  localparam int FLG_ERR  = 2;
  localparam int FLG_OVF  = 3;
  localparam int FLG_UNF  = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_OVF  = 2;
  localparam int IRQ_UNF  = 3;
  localparam int IRQ_W    = 4;
  localparam int CMP_EQ   = 0;
  localparam int CMP_NE   = 1;
  localparam int CMP_LT   = 2;
  localparam int CMP_LE   = 3;
  localparam int CMP_GT   = 4;
  localparam int CMP_GE   = 5;
  localparam int SIGN_BIT = 31;
  localparam int EXP_HI   = 30;
  localparam int EXP_LO   = 23;
  localparam int MAN_HI   = 22;

  // ----------------------------------------
  // Values and counts
  // ----------------------------------------
  localparam logic [7:0]        EXP_ONES   = 8'hFF;
  localparam logic [7:0]        EXP_INT_LO = 8'h7F;
  localparam logic [7:0]        EXP_INT_HI = 8'h9E;
  localparam logic signed [9:0] BIAS       = 10'sh07F;
  localparam logic signed [9:0] EXP_TOP    = 10'sh0FF;
  localparam logic [31:0]       NAN_WORD   = 32'h7FC0_0000;
  localparam logic [31:0]       ZERO_WORD  = 32'h0000_0000;
  localparam logic [31:0]       I16_POS    = 32'h0000_7FFF;
  localparam logic [31:0]       I16_NEG    = 32'h0000_8000;
  localparam logic [31:0]       I32_POS    = 32'h7FFF_FFFF;
  localparam logic [31:0]       I32_NEG    = 32'h8000_0000;
  localparam logic [4:0]        DIV_LAST   = 5'h19;
  localparam logic [3:0]        MASK_RESET = 4'h0;

  typedef enum logic [1:0] {
    FPR_IDLE   = 2'b00,
    FPR_EXEC   = 2'b01,
    FPR_DIVIDE = 2'b11,
    FPR_NORM   = 2'b10
  } fpr_state_t;
endpackage : fpr_pkg

// ---- logic/fpr_round.sv ----
/*
  Rounding and packing of a normalised working mantissa into a single-precision word.
  Assumes bit 26 of the mantissa is the hidden one, bits 2:0 guard, round, sticky.
*/
`timescale 1ns/100ps
module fpr_round (
  input  wire logic              sign,
  input  wire logic signed [9:0] exp_in,
  input  wire logic [27:0]       mant,
  output logic [31:0]            word,
  output logic                   ovf,
  output logic                   unf
);
  logic                up;
  logic [24:0]         rnd;
  logic signed [9:0]   exp_r;

  always_comb begin
    up    = mant[2] & (mant[1] | mant[0] | mant[3]);
    rnd   = {1'b0, mant[26:3]} + {24'h00_0000, up};
    exp_r = rnd[24] ? exp_in + 10'sh001 : exp_in;
    ovf   = 1'b0;
    unf   = 1'b0;
    if (mant == 28'h000_0000) begin
      word = {sign, 31'h0000_0000};
    end else if (exp_r >= fpr_pkg::EXP_TOP) begin
      word = {sign, fpr_pkg::EXP_ONES, 23'h00_0000};
      ovf  = 1'b1;
    end else if (exp_r <= 10'sh000) begin
      word = {sign, 31'h0000_0000};
      unf  = 1'b1;
    end else begin
      word = {sign, exp_r[7:0], rnd[24] ? rnd[23:1] : rnd[22:0]};
    end
  end
endmodule : fpr_round

// ---- logic/fpr_result_unit.sv ----
/*
  Single-precision arithmetic, compare and float-to-integer unit behind a Wishbone slave.
  Assumes a classic Wishbone master on CLOCK and software that polls busy or waits for IRQ.
*/
`timescale 1ns/100ps
// Function
// - Not-a-number has exponent 255 and a nonzero mantissa.
// - Inexact results round to nearest, ties to even last bit.
// - Too large magnitude gives signed infinity and sets overflow.
// - Too small magnitude gives signed zero and sets underflow.
// - Invalid infinity sums, zero times infinity, 0/0, inf/inf give not-a-number.
// - Positive zero plus negative zero is positive zero.
// - Difference of same-signed zeros is positive zero.
// - Any not-a-number operand of add, subtract, multiply or divide yields not-a-number.
// - Comparisons treat both zeros as equal.
// - With not-a-number, only not-equal is true.
// - Float results set the zero flag only when exponent and mantissa are zero; compare sets it when equal.
// - Integer conversion overflow gives an undefined value.
// - Float-to-integer truncates toward zero.
// - 16-bit conversion errors on not-a-number or out-of-range integer.
module fpr_result_unit (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ
);
  // ----------------------------------------
  // Reset release and bus
  // ----------------------------------------
  logic [1:0]  rst_sync;
  logic        rst_n;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  fpr_pkg::fpr_state_t state;
  logic [31:0] opa, opb, result, rd_mux;
  logic [2:0]  op;
  logic        zero_f, err_f, ovf_f, unf_f, done_p;
  logic [3:0]  irq_stat, irq_mask;
  logic        req, wr_go, start;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) if (sel[i]) m[8*i +: 8] = din[8*i +: 8];
    return m;
  endfunction : merge

  assign req   = WB_CYC_I & WB_STB_I;
  assign wr_go = req & WB_WE_I & WB_ACK_O;
  assign start = wr_go & (WB_ADR_I == fpr_pkg::ADR_CTRL) & WB_SEL_I[0] & (state == fpr_pkg::FPR_IDLE);

  always_comb begin
    if (WB_ADR_I == fpr_pkg::ADR_OPA) rd_mux = opa;
    else if (WB_ADR_I == fpr_pkg::ADR_OPB) rd_mux = opb;
    else if (WB_ADR_I == fpr_pkg::ADR_CTRL) rd_mux = {29'h0000_0000, op};
    else if (WB_ADR_I == fpr_pkg::ADR_RESULT) rd_mux = result;
    else if (WB_ADR_I == fpr_pkg::ADR_FLAGS)
      rd_mux = {27'h000_0000, unf_f, ovf_f, err_f, zero_f, state != fpr_pkg::FPR_IDLE};
    else if (WB_ADR_I == fpr_pkg::ADR_IRQ_STAT) rd_mux = {28'h000_0000, irq_stat};
    else if (WB_ADR_I == fpr_pkg::ADR_IRQ_MASK) rd_mux = {28'h000_0000, irq_mask};
    else rd_mux = fpr_pkg::ZERO_WORD;
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= fpr_pkg::ZERO_WORD;
    end else begin
      WB_ACK_O <= req & ~WB_ACK_O;
      if (req & ~WB_ACK_O) WB_DAT_O <= rd_mux;
    end
  end

  // Operands are locked while busy so a divide sees stable inputs
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      opa      <= fpr_pkg::ZERO_WORD;
      opb      <= fpr_pkg::ZERO_WORD;
      irq_mask <= fpr_pkg::MASK_RESET;
    end else if (wr_go) begin
      if (WB_ADR_I == fpr_pkg::ADR_OPA && state == fpr_pkg::FPR_IDLE) opa <= merge(opa, WB_DAT_I, WB_SEL_I);
      else if (WB_ADR_I == fpr_pkg::ADR_OPB && state == fpr_pkg::FPR_IDLE) opb <= merge(opb, WB_DAT_I, WB_SEL_I);
      else if (WB_ADR_I == fpr_pkg::ADR_IRQ_MASK && WB_SEL_I[0]) irq_mask <= WB_DAT_I[3:0];
    end
  end

  // ----------------------------------------
  // Operand decode
  // ----------------------------------------
  logic              a_s, b_s, bs, a_zero, b_zero, a_inf, b_inf, a_nan, b_nan, ps;
  logic [7:0]        a_exp, b_exp;
  logic [23:0]       a_m, b_m;
  logic signed [9:0] ea, eb;
  assign a_s    = opa[fpr_pkg::SIGN_BIT];
  assign b_s    = opb[fpr_pkg::SIGN_BIT];
  assign a_exp  = opa[fpr_pkg::EXP_HI:fpr_pkg::EXP_LO];
  assign b_exp  = opb[fpr_pkg::EXP_HI:fpr_pkg::EXP_LO];
  // Subnormal operands are flushed to signed zero in arithmetic
  assign a_zero = (a_exp == 8'h00);
  assign b_zero = (b_exp == 8'h00);
  assign a_inf  = (a_exp == fpr_pkg::EXP_ONES) && (opa[fpr_pkg::MAN_HI:0] == 23'h00_0000);
  assign b_inf  = (b_exp == fpr_pkg::EXP_ONES) && (opb[fpr_pkg::MAN_HI:0] == 23'h00_0000);
  assign a_nan  = (a_exp == fpr_pkg::EXP_ONES) && !a_inf;
  assign b_nan  = (b_exp == fpr_pkg::EXP_ONES) && !b_inf;
  assign a_m    = {~a_zero, opa[fpr_pkg::MAN_HI:0]};
  assign b_m    = {~b_zero, opb[fpr_pkg::MAN_HI:0]};
  assign ea     = $signed({2'b00, a_exp});
  assign eb     = $signed({2'b00, b_exp});
  assign bs     = b_s ^ (op == fpr_pkg::OP_SUB);
  assign ps     = a_s ^ b_s;

  // ----------------------------------------
  // Add, multiply, compare and convert paths
  // ----------------------------------------
  logic        a_big, stk, add_sign, eq, lt;
  logic [7:0]  d;
  logic [27:0] big_x, sm_x, al, sum;
  logic [47:0] prod;
  logic [54:0] f_wide;
  logic [31:0] f_mag, f_int;
  logic [5:0]  cmp;

  always_comb begin
    a_big = opa[30:0] >= opb[30:0];
    big_x = {1'b0, a_big ? a_m : b_m, 3'b000};
    sm_x  = {1'b0, a_big ? b_m : a_m, 3'b000};
    d     = a_big ? a_exp - b_exp : b_exp - a_exp;
    // keep a sticky bit of what is shifted out
    stk   = (d > 8'h1B) ? |sm_x : |(sm_x & ~(28'hFFF_FFFF << d));
    al    = ((d > 8'h1B) ? 28'h000_0000 : sm_x >> d) | {27'h000_0000, stk};
    sum   = (a_s == bs) ? big_x + al : big_x - al;
    add_sign = (sum == 28'h000_0000) ? 1'b0 : (a_big ? a_s : bs);
    prod  = a_m * b_m;
    eq    = (opa == opb) || (opa[30:0] == 31'h0000_0000 && opb[30:0] == 31'h0000_0000);
    lt    = !eq && ((a_s != b_s) ? a_s : (a_s ? opa[30:0] > opb[30:0] : opa[30:0] < opb[30:0]));
    cmp   = 6'h00;
    if (a_nan || b_nan) cmp[fpr_pkg::CMP_NE] = 1'b1;
    else begin
      cmp[fpr_pkg::CMP_EQ] = eq;
      cmp[fpr_pkg::CMP_NE] = !eq;
      cmp[fpr_pkg::CMP_LT] = lt;
      cmp[fpr_pkg::CMP_LE] = lt | eq;
      cmp[fpr_pkg::CMP_GT] = !lt & !eq;
      cmp[fpr_pkg::CMP_GE] = !lt;
    end
    f_wide = {31'h0000_0000, a_m} << 5'(a_exp - fpr_pkg::EXP_INT_LO);
    f_mag  = (a_exp < fpr_pkg::EXP_INT_LO) ? fpr_pkg::ZERO_WORD : f_wide[54:23];
    f_int  = a_s ? ~f_mag + 32'h0000_0001 : f_mag;
  end

  // ----------------------------------------
  // Results settled in one cycle
  // ----------------------------------------
  logic        ex_fin, ex_err, ex_zero;
  logic [31:0] ex_word;
  always_comb begin
    ex_fin  = 1'b1;
    ex_err  = 1'b0;
    ex_word = fpr_pkg::NAN_WORD;
    if (op == fpr_pkg::OP_CMP) ex_word = {26'h000_0000, cmp};
    else if (op == fpr_pkg::OP_FIX16) begin
      ex_word = {{16{f_int[15]}}, f_int[15:0]};
      ex_err  = a_nan || a_exp > fpr_pkg::EXP_INT_HI
                || (a_s ? f_mag > fpr_pkg::I16_NEG : f_mag > fpr_pkg::I16_POS);
    end else if (op == fpr_pkg::OP_FIX32) begin
      // out of range value left undefined
      ex_word = f_int;
      ex_err  = a_nan || a_exp > fpr_pkg::EXP_INT_HI
                || (a_s ? f_mag > fpr_pkg::I32_NEG : f_mag > fpr_pkg::I32_POS);
    end else if (a_nan || b_nan) ex_err = 1'b1;
    else begin
      case (op)
        fpr_pkg::OP_ADD, fpr_pkg::OP_SUB: begin
          if (a_inf && b_inf && (a_s ^ bs)) ex_err = 1'b1;
          else if (a_inf) ex_word = {a_s, fpr_pkg::EXP_ONES, 23'h00_0000};
          else if (b_inf) ex_word = {bs, fpr_pkg::EXP_ONES, 23'h00_0000};
          else if (a_zero && b_zero) ex_word = {a_s & bs, 31'h0000_0000};
          else if (a_zero) ex_word = {bs, opb[30:0]};
          else if (b_zero) ex_word = opa;
          else ex_fin = 1'b0;
        end
        fpr_pkg::OP_MUL: begin
          if ((a_inf && b_zero) || (a_zero && b_inf)) ex_err = 1'b1;
          else if (a_inf || b_inf) ex_word = {ps, fpr_pkg::EXP_ONES, 23'h00_0000};
          else if (a_zero || b_zero) ex_word = {ps, 31'h0000_0000};
          else ex_fin = 1'b0;
        end
        fpr_pkg::OP_DIV: begin
          if ((a_zero && b_zero) || (a_inf && b_inf)) ex_err = 1'b1;
          else if (a_inf || b_zero) ex_word = {ps, fpr_pkg::EXP_ONES, 23'h00_0000};
          else if (a_zero || b_inf) ex_word = {ps, 31'h0000_0000};
          else ex_fin = 1'b0;
        end
        default: ex_err = 1'b1;
      endcase
    end
    // float zero needs zero exponent and mantissa
    if (op == fpr_pkg::OP_CMP) ex_zero = cmp[fpr_pkg::CMP_EQ];
    else if (op == fpr_pkg::OP_FIX16 || op == fpr_pkg::OP_FIX32) ex_zero = (ex_word == fpr_pkg::ZERO_WORD);
    else ex_zero = (ex_word[30:0] == 31'h0000_0000);
  end

  // ----------------------------------------
  // Sequencer: divide, normalise, round
  // ----------------------------------------
  logic [27:0]       mant;
  logic signed [9:0] wexp;
  logic              wsign, qbit, norm_end, r_ovf, r_unf;
  logic [24:0]       rem, diff;
  logic [4:0]        steps;
  logic [31:0]       r_word;

  assign diff     = rem - {1'b0, b_m};
  assign qbit     = !diff[24];
  assign norm_end = !mant[27] && !(mant != 28'h000_0000 && !mant[26] && wexp > 10'sh000);

  fpr_round u_round (
    .sign   (wsign),
    .exp_in (wexp),
    .mant   (mant),
    .word   (r_word),
    .ovf    (r_ovf),
    .unf    (r_unf)
  );

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state  <= fpr_pkg::FPR_IDLE;
      op     <= fpr_pkg::OP_ADD;
      result <= fpr_pkg::ZERO_WORD;
      {zero_f, err_f, ovf_f, unf_f, done_p, wsign} <= 6'h00;
      mant   <= 28'h000_0000;
      wexp   <= 10'sh000;
      rem    <= 25'h000_0000;
      steps  <= 5'h00;
    end else begin
      done_p <= 1'b0;
      case (state)
        fpr_pkg::FPR_IDLE: if (start) begin
          op    <= WB_DAT_I[2:0];
          state <= fpr_pkg::FPR_EXEC;
        end
        fpr_pkg::FPR_EXEC: if (ex_fin) begin
          result <= ex_word;
          {zero_f, err_f, ovf_f, unf_f, done_p} <= {ex_zero, ex_err, 3'b001};
          state  <= fpr_pkg::FPR_IDLE;
        end else if (op == fpr_pkg::OP_DIV) begin
          {wsign, wexp, rem, steps} <= {ps, ea - eb + fpr_pkg::BIAS, 1'b0, a_m, 5'h00};
          state <= fpr_pkg::FPR_DIVIDE;
        end else if (op == fpr_pkg::OP_MUL) begin
          {wsign, wexp, mant} <= {ps, ea + eb - fpr_pkg::BIAS, prod[47:21], |prod[20:0]};
          state <= fpr_pkg::FPR_NORM;
        end else begin
          {wsign, wexp, mant} <= {add_sign, a_big ? ea : eb, sum};
          state <= fpr_pkg::FPR_NORM;
        end
        fpr_pkg::FPR_DIVIDE: begin
          rem   <= qbit ? {diff[23:0], 1'b0} : {rem[23:0], 1'b0};
          steps <= steps + 5'h01;
          // Restoring divide; the last step folds the remainder into sticky
          if (steps == fpr_pkg::DIV_LAST) begin
            mant  <= {1'b0, mant[24:0], qbit, qbit ? diff != 25'h000_0000 : rem != 25'h000_0000};
            state <= fpr_pkg::FPR_NORM;
          end else mant <= {mant[26:0], qbit};
        end
        default: begin
          // One bit per cycle keeps the shifter small at the cost of latency
          if (mant[27]) begin
            mant <= {1'b0, mant[27:2], mant[1] | mant[0]};
            wexp <= wexp + 10'sh001;
          end else if (!norm_end) begin
            mant <= {mant[26:0], 1'b0};
            wexp <= wexp - 10'sh001;
          end else begin
            result <= r_word;
            {zero_f, err_f, ovf_f, unf_f, done_p} <= {r_word[30:0] == 31'h0000_0000, 1'b0, r_ovf, r_unf, 1'b1};
            state  <= fpr_pkg::FPR_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [3:0] evt, w1c;
  assign evt = {done_p & unf_f, done_p & ovf_f, done_p & err_f, done_p};
  assign w1c = (wr_go && WB_ADR_I == fpr_pkg::ADR_IRQ_STAT && WB_SEL_I[0]) ? WB_DAT_I[3:0] : 4'h0;
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 4'h0;
      IRQ      <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~w1c) | evt;
      IRQ      <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);
  logic ex_arith, both_z;
  assign ex_arith = (state == fpr_pkg::FPR_EXEC) && (op <= fpr_pkg::OP_DIV);
  assign both_z   = opa[30:0] == 31'h0000_0000 && opb[30:0] == 31'h0000_0000;

  property p_nan_code;
    done_p && err_f && op <= fpr_pkg::OP_DIV |-> result[30:23] == 8'hFF && result[22:0] != 23'h00_0000;
  endproperty
  a_nan_code: assert property (p_nan_code) else $error("nan result badly encoded");
  property p_tie_even;
    state == fpr_pkg::FPR_NORM && norm_end && mant[3:0] == 4'b0100 && wexp > 10'sh000 && wexp < 10'sh0FE
      |=> result[22:0] == $past(mant[25:3]);
  endproperty
  a_tie_even: assert property (p_tie_even) else $error("tie not rounded to even");
  property p_ovf_inf;
    done_p && ovf_f |-> result[30:0] == 31'h7F80_0000 && !unf_f;
  endproperty
  a_ovf_inf: assert property (p_ovf_inf) else $error("overflow without infinity");
  property p_unf_zero;
    done_p && unf_f |-> result[30:0] == 31'h0000_0000 && zero_f;
  endproperty
  a_unf_zero: assert property (p_unf_zero) else $error("underflow without zero");
  property p_zero_inf;
    ex_arith && op == fpr_pkg::OP_MUL && ((a_zero && b_inf) || (a_inf && b_zero)) |=> done_p && err_f;
  endproperty
  a_zero_inf: assert property (p_zero_inf) else $error("zero times infinity accepted");
  property p_zero_sum;
    ex_arith && op <= fpr_pkg::OP_SUB && both_z && (a_s ^ bs) |=> result == fpr_pkg::ZERO_WORD;
  endproperty
  a_zero_sum: assert property (p_zero_sum) else $error("mixed zero sum not positive");
  property p_nan_in;
    ex_arith && (a_nan || b_nan) |=> done_p ##0 result[30:23] == 8'hFF ##1 irq_stat[fpr_pkg::IRQ_ERR];
  endproperty
  a_nan_in: assert property (p_nan_in) else $error("nan operand lost");
  property p_cmp_nan;
    state == fpr_pkg::FPR_EXEC && op == fpr_pkg::OP_CMP && (a_nan || b_nan) |=> result[5:0] == 6'h02;
  endproperty
  a_cmp_nan: assert property (p_cmp_nan) else $error("nan compare not only unequal");
  property p_cmp_zero;
    state == fpr_pkg::FPR_EXEC && op == fpr_pkg::OP_CMP && both_z |=> result[fpr_pkg::CMP_EQ] && zero_f;
  endproperty
  a_cmp_zero: assert property (p_cmp_zero) else $error("zeros compare unequal");
  property p_zero_flag;
    done_p && op <= fpr_pkg::OP_DIV |-> zero_f == (result[30:0] == 31'h0000_0000);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");
  property p_fix_err;
    state == fpr_pkg::FPR_EXEC && op == fpr_pkg::OP_FIX16 && (a_nan || a_exp > 8'h8E) |=> err_f && done_p;
  endproperty
  a_fix_err: assert property (p_fix_err) else $error("16-bit range error missed");
  property p_fix_frac;
    state == fpr_pkg::FPR_EXEC && op == fpr_pkg::OP_FIX16 && a_exp < 8'h7F |=> result == fpr_pkg::ZERO_WORD;
  endproperty
  a_fix_frac: assert property (p_fix_frac) else $error("fraction not truncated");
  c_add: cover property (done_p && op == fpr_pkg::OP_ADD && !err_f);
  c_div: cover property (done_p && op == fpr_pkg::OP_DIV && !err_f);
  c_ovf: cover property (done_p && ovf_f);
  c_irq: cover property (IRQ);
endmodule : fpr_result_unit

// ---- tb/fpr_host_model.sv ----
/*
  Host model: the instruction side that issues operations over classic Wishbone.
  Assumes one clock and a slave that answers every request with ack.
*/
`timescale 1ns/100ps
module fpr_host_model (
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  input  wire logic [31:0] din,
  input  wire logic        ack
);
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end

  // ----------------------------------------
  // One classic cycle
  // ----------------------------------------
  // Request held until the ack edge; write data inverted once released
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = din;
    {cyc, stb, we} <= 3'b000;
    dat <= ~d;
    @(posedge clk);
  endtask : xfer
endmodule : fpr_host_model

// ---- tb/tb_fpr_result_unit.sv ----
/*
  Testbench of the result unit: operations issued as register sequences with expected values.
  Assumes the host model as the only bus master and a 100 MHz clock.
*/
`timescale 1ns/100ps
module tb_fpr_result_unit;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, q;
  int          bad_count = 0;
  int          total_checks = 0;

  always #5 clock = ~clock;

  fpr_host_model host (.clk(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
                       .dat(dat_w), .din(dat_r), .ack(ack));
  fpr_result_unit uut (.CLOCK(clock), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
                       .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w),
                       .WB_DAT_O(dat_r), .WB_ACK_O(ack), .IRQ(irq));

  task check(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // Operation sequence
  // ----------------------------------------
  // Result compared when cr is set or NaN is expected; NaN judged by field pattern, not one word
  task run(input logic [2:0] op, input logic [31:0] a, b, r, input logic cr, input logic [4:0] f, fm);
    logic [31:0] res;
    host.xfer(1'b1, fpr_pkg::ADR_OPA, a, q);
    host.xfer(1'b1, fpr_pkg::ADR_OPB, b, q);
    host.xfer(1'b1, fpr_pkg::ADR_CTRL, {29'h0, op}, q);
    // The write's own read data is stale, so flags are always read at least once
    q = 32'h0000_0001;
    for (int i = 0; i < 60 && q[fpr_pkg::FLG_BUSY] !== 1'b0; i++) host.xfer(1'b0, fpr_pkg::ADR_FLAGS, 32'h0, q);
    check("busy", {31'h0, q[fpr_pkg::FLG_BUSY]}, 32'h0);
    host.xfer(1'b0, fpr_pkg::ADR_RESULT, 32'h0, res);
    if (r === fpr_pkg::NAN_WORD) check("nan", {31'h0, res[30:23] == 8'hFF && res[22:0] != 0}, 32'h1);
    else if (cr) check("result", res, r);
    check("flags", {27'h0, q[4:0] & fm}, {27'h0, f & fm});
  endtask : run

  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    host.xfer(1'b0, fpr_pkg::ADR_IRQ_MASK, 32'h0, q);
    check("mask reset", q, 32'h0);
    host.xfer(1'b0, 8'h1C, 32'h0, q);
    check("unmapped", q, 32'h0);
    run(fpr_pkg::OP_ADD, 32'h7F80_0000, 32'hFF80_0000, fpr_pkg::NAN_WORD, 1, 5'h04, 5'h1F);
    run(fpr_pkg::OP_SUB, 32'h7F80_0000, 32'h7F80_0000, fpr_pkg::NAN_WORD, 1, 5'h04, 5'h1F);
    run(fpr_pkg::OP_MUL, 32'h0000_0000, 32'h7F80_0000, fpr_pkg::NAN_WORD, 1, 5'h04, 5'h1F);
    run(fpr_pkg::OP_DIV, 32'h0000_0000, 32'h0000_0000, fpr_pkg::NAN_WORD, 1, 5'h04, 5'h1F);
    run(fpr_pkg::OP_DIV, 32'hFF80_0000, 32'h7F80_0000, fpr_pkg::NAN_WORD, 1, 5'h04, 5'h1F);
    run(fpr_pkg::OP_MUL, 32'h7FC0_0000, 32'h3F80_0000, fpr_pkg::NAN_WORD, 1, 5'h04, 5'h1F);
    run(3'h7, 32'h3F80_0000, 32'h3F80_0000, fpr_pkg::NAN_WORD, 1, 5'h04, 5'h1F);
    run(fpr_pkg::OP_ADD, 32'h0000_0000, 32'h8000_0000, 32'h0000_0000, 1, 5'h02, 5'h1F);
    run(fpr_pkg::OP_SUB, 32'h8000_0000, 32'h8000_0000, 32'h0000_0000, 1, 5'h02, 5'h1F);
    run(fpr_pkg::OP_ADD, 32'h3F80_0000, 32'hBF80_0000, 32'h0000_0000, 1, 5'h02, 5'h1F);
    run(fpr_pkg::OP_ADD, 32'h3F80_0000, 32'h3380_0000, 32'h3F80_0000, 1, 5'h00, 5'h1F);
    run(fpr_pkg::OP_ADD, 32'h3F80_0001, 32'h3380_0000, 32'h3F80_0002, 1, 5'h00, 5'h1F);
    run(fpr_pkg::OP_ADD, 32'h3F80_0000, 32'h33C0_0000, 32'h3F80_0001, 1, 5'h00, 5'h1F);
    run(fpr_pkg::OP_DIV, 32'h4040_0000, 32'h4000_0000, 32'h3FC0_0000, 1, 5'h00, 5'h1F);
    run(fpr_pkg::OP_MUL, 32'hFF00_0000, 32'h7F00_0000, 32'hFF80_0000, 1, 5'h08, 5'h1F);
    run(fpr_pkg::OP_MUL, 32'h8080_0000, 32'h0080_0000, 32'h8000_0000, 1, 5'h12, 5'h1F);
    run(fpr_pkg::OP_CMP, 32'h0000_0000, 32'h8000_0000, 32'h0000_0029, 1, 5'h02, 5'h02);
    run(fpr_pkg::OP_CMP, 32'h7FC0_0000, 32'h3F80_0000, 32'h0000_0002, 1, 5'h00, 5'h02);
    run(fpr_pkg::OP_FIX16, 32'hC060_0000, 32'h0, 32'hFFFF_FFFD, 1, 5'h00, 5'h1F);
    run(fpr_pkg::OP_FIX16, 32'hBF00_0000, 32'h0, 32'h0, 1, 5'h02, 5'h1F);
    run(fpr_pkg::OP_FIX32, 32'hCF00_0000, 32'h0, 32'h8000_0000, 1, 5'h00, 5'h1F);
    run(fpr_pkg::OP_FIX16, 32'h46FF_FE00, 32'h0, 32'h0000_7FFF, 1, 5'h00, 5'h1F);
    run(fpr_pkg::OP_FIX16, 32'hC700_0000, 32'h0, 32'hFFFF_8000, 1, 5'h00, 5'h1F);
    run(fpr_pkg::OP_FIX16, 32'h4700_0000, 32'h0, 32'h0, 0, 5'h04, 5'h04);
    run(fpr_pkg::OP_FIX16, 32'h7FC0_0000, 32'h0, 32'h0, 0, 5'h04, 5'h04);
    // Done event: sticky, masked, then cleared by writing one
    host.xfer(1'b0, fpr_pkg::ADR_IRQ_STAT, 32'h0, q);
    check("done status", {31'h0, q[fpr_pkg::IRQ_DONE]}, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    host.xfer(1'b1, fpr_pkg::ADR_IRQ_MASK, 32'h0000_0001, q);
    repeat (3) @(posedge clock);
    check("irq raised", {31'h0, irq}, 32'h1);
    host.xfer(1'b1, fpr_pkg::ADR_IRQ_STAT, 32'h0000_000F, q);
    repeat (3) @(posedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
    host.xfer(1'b0, fpr_pkg::ADR_IRQ_STAT, 32'h0, q);
    check("status cleared", q, 32'h0);
    wrap_up();
  end

  // Whole sequence needs well under 10k cycles
  initial begin
    #100us;
    bad_count++;
    wrap_up();
  end
endmodule : tb_fpr_result_unit
